/* File: osp_consts.svh */
// Purpose: constants of the OSD display window block
// Assumes: byte registers at 16-bit addresses, 20 MHz clock
// Notes: definitions only
`ifndef OSP_CONSTS_SVH
`define OSP_CONSTS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define OSP_A_DCTL 16'h87F0
`define OSP_A_VPOS 16'h87F1
`define OSP_A_HSTA 16'h87F2
`define OSP_A_HEND 16'h87F4
`define OSP_A_SAREA 16'h87F5
`define OSP_A_SRNG 16'h87F6
`define OSP_A_STAT 16'h87F8
`define OSP_A_TSL 16'h87FE
`define OSP_A_CFG 16'h87FF
`define OSP_A_HSTB 16'h87E0
`define OSP_A_HENDB 16'h87E1
`define OSP_A_PGB 16'h87E2
`define OSP_A_VPOSB 16'h87E3
`define OSP_A_VRNG 16'h87E4
`define OSP_A_TXA 16'h87E8
`define OSP_A_TXB 16'h87E9
// ----------------------------------------
// Register indices in the byte array
// ----------------------------------------
`define OSP_R_DCTL 4'h0
`define OSP_R_VPOS 4'h1
`define OSP_R_HSTA 4'h2
`define OSP_R_HEND 4'h3
`define OSP_R_SAREA 4'h4
`define OSP_R_SRNG 4'h5
`define OSP_R_STAT 4'h6
`define OSP_R_TSL 4'h7
`define OSP_R_CFG 4'h8
`define OSP_R_HSTB 4'h9
`define OSP_R_HENDB 4'hA
`define OSP_R_PGB 4'hB
`define OSP_R_VPOSB 4'hC
`define OSP_R_VRNG 4'hD
`define OSP_R_TXA 4'hE
`define OSP_R_TXB 4'hF
// Writable bits per register, index 15 first
`define OSP_WMASK {8'h87, 8'h7F, 8'h3F, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFB, \
	8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hF7}
`define OSP_RESET_BYTE 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OSP_VP_HPOL 6
`define OSP_VP_VPOL 7
`define OSP_CFG_CAPT 7
`define OSP_CFG_TELE 3
`define OSP_CFG_TWO 0
`define OSP_ST_SCROLL 5
`define OSP_TX_PIC 4
`define OSP_TX_TEXT 5
`define OSP_TX_BACK 6
`define OSP_TX_STD525 7
`define OSP_MAP_EN_BIT 11
// ----------------------------------------
// Timing, times in ns
// ----------------------------------------
`define OSP_CLK_MHZ 20
`define OSP_SCW_START_NS 10500
`define OSP_SCW_END_NS 62500
`define OSP_SCA_START_NS 8000
`define OSP_SCA_LEN_NS 56000
`define OSP_CYC_UP(ns) ((((ns) * `OSP_CLK_MHZ) + 999) / 1000)
`define OSP_CYC_DN(ns) (((ns) * `OSP_CLK_MHZ) / 1000)
// ----------------------------------------
// Lines, rows and columns
// ----------------------------------------
`define OSP_L625_FIRST 9'h017
`define OSP_L625_LAST 9'h136
`define OSP_L525_FIRST 9'h011
`define OSP_L525_LAST 9'h104
`define OSP_SCA_FIRST 9'h009
`define OSP_TEXT_LINES 10'h100
`define OSP_MAP_BASE 16'h8000
`define OSP_MAP_ROWS 5'h10
`define OSP_TELE_ROWS 5'h19
`define OSP_TELE_COLS 6'h28
`define OSP_MAX_CHARS 6'h30
`endif

/* File: osp_pkg.sv */
// Purpose: types of the OSD display window block
// Assumes: one clock domain
// Notes: registers are held as a flat byte array
package osp_pkg;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	// Sixteen byte-wide registers
	typedef logic [15:0][7:0] osp_bytes_t;
	// Source of each output pixel
	typedef enum logic [1:0] {OSP_VIDEO, OSP_BLACK, OSP_CLUT} osp_src_e;
	// Whole state of the block
	typedef struct packed {
		osp_bytes_t sh; // Shadow set, written by software
		osp_bytes_t ac; // Active set, used by the display
		logic [2:0] hs_s; // Line sync synchroniser
		logic [2:0] vs_s; // Field sync synchroniser
		logic hs_l; // Accepted line sync level
		logic vs_l; // Accepted field sync level
		logic [10:0] hcnt; // Clocks since line sync
		logic [3:0] qdiv; // Quarter character divider
		logic [9:0] qcnt; // Quarter characters since line sync
		logic [8:0] vline; // Line number in field
		logic field; // Field parity
		logic [4:0] rline; // Scan line in display row
		logic [4:0] row; // Display row
		logic in_win; // Fetched row is in scroll window
		logic row_blank; // Fetched row is outside scroll range
		logic map_rd; // Row map read strobe
		logic rd_pend; // Row map data due now
		logic [15:0] map_addr; // Row map word address
		logic [15:0] row_ptr; // Row data word address
		logic row_on; // Row text enabled
		logic [3:0] row_ln; // Scan line for glyph lookup
		logic [3:0] pix_idx; // Colour lookup index
		osp_src_e src; // Pixel source
		logic text_a; // Inside text area A
		logic text_b; // Inside text area B
		logic sc_win; // Inside screen colour area
		logic busy_p; // Display busy pulse
		logic [7:0] rdata; // Read data
	} osp_state_s;
endpackage

/* File: osp_screen_scroll.sv */
// Purpose: screen colour, text area placement and soft scroll of an OSD
// Assumes: 20 MHz clock; sync pins asynchronous; glyph pixels same clock
// Notes: display uses a register set copied at each field sync
// Functional notes
// - Picture, text, background bits mix teletext output
// - Screen colour from 10.5 to 62.5 us
// - Screen colour lines 23-310 or 17-260
// - Caption screen colour index from display control
// - Teletext screen colour zero transparent, else 9-15
// - Page B uses its own screen colour
// - Sixteen-word row map gives row data pointer
// - Map bit 11 enables rows outside scroll
// - One scroll region, only while scroll enabled
// - Window position, height and row range set scroll
// - Scroll writes apply at next field sync
// - Teletext page is 25 rows by 40 columns
// - Screen colour area 56 us, from line 9
// - Text start 3-64 chars plus quarter offset; the start field here takes 0-63
// - End character stops background and fetching
// - Text area 256 lines after vertical offset
// - No busy pulse when vertical offset zero
// - Page B placed by its own position register
// - Two-bit display mode selects four outputs
`timescale 1ns/1ps
`include "osp_consts.svh"

module osp_screen_scroll
	import osp_pkg::*;
#(
	parameter int QTR_CYC = 3, // Clocks per quarter character
	parameter int ROW_LINES = 10 // Scan lines per display row
)(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic HSYNC,
	input wire logic VSYNC,
	input wire logic FG_PIX,
	input wire logic BG_PIX,
	input wire logic BOX_PIX,
	input wire logic [3:0] FG_IDX,
	input wire logic [3:0] BG_IDX,
	input wire logic [15:0] MAP_DATA,
	output logic MAP_RD,
	output logic [15:0] MAP_ADDR,
	output logic [15:0] ROW_PTR,
	output logic ROW_ON,
	output logic [3:0] ROW_LINE,
	output osp_src_e PIX_SRC,
	output logic [3:0] PIX_IDX,
	output logic TEXT_A,
	output logic TEXT_B,
	output logic SC_WIN,
	output logic DISP_BUSY
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam osp_bytes_t WMASK = `OSP_WMASK;
	// Screen colour limits in clocks after line sync
	localparam logic [10:0] SCW_BEG = 11'(`OSP_CYC_UP(`OSP_SCW_START_NS));
	localparam logic [10:0] SCW_END = 11'(`OSP_CYC_DN(`OSP_SCW_END_NS));
	localparam logic [10:0] SCA_BEG = 11'(`OSP_CYC_UP(`OSP_SCA_START_NS));
	localparam logic [10:0] SCA_END = 11'(`OSP_CYC_DN(`OSP_SCA_START_NS + `OSP_SCA_LEN_NS));
	osp_state_s s_q; // Registered state
	osp_state_s s_d; // Next state
	logic hedge; // Leading edge of line sync
	logic fsync; // Leading edge of field sync
	logic capt_m; // Caption mode
	logic tele_m; // Teletext-style mode
	logic two_pg; // Double window
	logic std525; // 525-line timing
	logic scroll_on; // Scroll region live
	logic win_now; // Current row in scroll window
	logic carry; // Line offset spills into next row
	logic txt_v; // Current line in text area
	logic hit; // Address maps to a register
	logic in_ta; // Pixel inside text area A
	logic in_tb; // Pixel inside text area B
	logic [3:0] ri; // Register index
	logic [3:0] scroll_window_position; // Scroll window position
	logic [3:0] scroll_window_height; // Scroll window height
	logic [3:0] sts; // First row of scroll range
	logic [3:0] scroll_last_row_range; // Last row of scroll range
	logic [3:0] first_scrolled_row; // First scrolled row
	logic [3:0] scl; // Scroll line offset
	logic [2:0] sc_cur; // Teletext screen colour here
	logic [4:0] sl; // Offset scan line
	logic [4:0] disp_row; // Row shown through window
	logic [4:0] rows_max; // Rows in the page
	logic [5:0] cols; // Columns in the page
	logic [5:0] end_a; // Clamped end character A
	logic [5:0] end_b; // Clamped end character B
	logic [9:0] a_beg; // Text area A start, quarters
	logic [9:0] b_beg; // Text area B start, quarters
	logic [9:0] vbeg; // First text line
	logic [9:0] nv; // Next line number
	logic [7:0] rd_val; // Read data before register
	osp_src_e src_n; // Pixel source before register
	logic [3:0] idx_n; // Pixel index before register
	logic [15:0] exp_ptr; // Expected row pointer, checks only
	logic exp_on; // Expected map enable bit, checks only

	// ----------------------------------------
	// Outputs, straight from the state
	// ----------------------------------------
	assign RDATA = s_q.rdata;
	assign MAP_RD = s_q.map_rd;
	assign MAP_ADDR = s_q.map_addr;
	assign ROW_PTR = s_q.row_ptr;
	assign ROW_ON = s_q.row_on;
	assign ROW_LINE = s_q.row_ln;
	assign PIX_SRC = s_q.src;
	assign PIX_IDX = s_q.pix_idx;
	assign TEXT_A = s_q.text_a;
	assign TEXT_B = s_q.text_b;
	assign SC_WIN = s_q.sc_win;
	assign DISP_BUSY = s_q.busy_p;

	// ----------------------------------------
	// Register address decode
	// ----------------------------------------
	// Map the sparse addresses onto the byte array
	always_comb
	begin
		ri = `OSP_R_DCTL;
		hit = 1'b1;
		unique case (ADDR)
			`OSP_A_DCTL: ri = `OSP_R_DCTL;
			`OSP_A_VPOS: ri = `OSP_R_VPOS;
			`OSP_A_HSTA: ri = `OSP_R_HSTA;
			`OSP_A_HEND: ri = `OSP_R_HEND;
			`OSP_A_SAREA: ri = `OSP_R_SAREA;
			`OSP_A_SRNG: ri = `OSP_R_SRNG;
			`OSP_A_STAT: ri = `OSP_R_STAT;
			`OSP_A_TSL: ri = `OSP_R_TSL;
			`OSP_A_CFG: ri = `OSP_R_CFG;
			`OSP_A_HSTB: ri = `OSP_R_HSTB;
			`OSP_A_HENDB: ri = `OSP_R_HENDB;
			`OSP_A_PGB: ri = `OSP_R_PGB;
			`OSP_A_VPOSB: ri = `OSP_R_VPOSB;
			`OSP_A_VRNG: ri = `OSP_R_VRNG;
			`OSP_A_TXA: ri = `OSP_R_TXA;
			`OSP_A_TXB: ri = `OSP_R_TXB;
			default: hit = 1'b0; // Unmapped, reads zero
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.busy_p = 1'b0;
		s_d.map_rd = 1'b0;
		s_d.rd_pend = s_q.map_rd;
		// Controls from the active set only
		capt_m = s_q.ac[`OSP_R_CFG][`OSP_CFG_CAPT];
		tele_m = s_q.ac[`OSP_R_CFG][`OSP_CFG_TELE] && !capt_m;
		two_pg = s_q.ac[`OSP_R_CFG][`OSP_CFG_TWO];
		std525 = s_q.ac[`OSP_R_TXB][`OSP_TX_STD525];
		scroll_window_position = s_q.ac[`OSP_R_SAREA][3:0];
		scroll_window_height = s_q.ac[`OSP_R_SAREA][7:4];
		sts = s_q.ac[`OSP_R_SRNG][3:0];
		scroll_last_row_range = s_q.ac[`OSP_R_SRNG][7:4];
		first_scrolled_row = s_q.ac[`OSP_R_STAT][3:0];
		scl = s_q.ac[`OSP_R_TSL][3:0];
		// Pins pass three flops; second and third must agree
		s_d.hs_s = {s_q.hs_s[1:0], HSYNC};
		s_d.vs_s = {s_q.vs_s[1:0], VSYNC};
		hedge = 1'b0;
		fsync = 1'b0;
		if (s_q.hs_s[1] == s_q.hs_s[2] && s_q.hs_s[2] != s_q.hs_l)
		begin
			s_d.hs_l = s_q.hs_s[2];
			hedge = s_q.hs_s[2] == s_q.ac[`OSP_R_VPOS][`OSP_VP_HPOL];
		end
		if (s_q.vs_s[1] == s_q.vs_s[2] && s_q.vs_s[2] != s_q.vs_l)
		begin
			s_d.vs_l = s_q.vs_s[2];
			fsync = s_q.vs_s[2] == s_q.ac[`OSP_R_VPOS][`OSP_VP_VPOL];
		end
		// Horizontal counters restart at line sync
		if (hedge)
		begin
			s_d.hcnt = 11'h000;
			s_d.qdiv = 4'h0;
			s_d.qcnt = 10'h000;
		end
		else
		begin
			if (s_q.hcnt != 11'h7FF)
				s_d.hcnt = s_q.hcnt + 11'h001;
			if (s_q.qdiv == 4'(QTR_CYC - 1))
			begin
				s_d.qdiv = 4'h0;
				if (s_q.qcnt != 10'h3FF)
					s_d.qcnt = s_q.qcnt + 10'h001;
			end
			else
				s_d.qdiv = s_q.qdiv + 4'h1;
		end
		// Text area lines follow the vertical offset
		vbeg = {4'h0, s_q.ac[`OSP_R_VPOS][5:0]} + 10'h001;
		txt_v = {1'b0, s_q.vline} >= vbeg && {1'b0, s_q.vline} < vbeg + `OSP_TEXT_LINES;
		nv = {1'b0, s_q.vline} + 10'h001;
		rows_max = tele_m ? `OSP_TELE_ROWS : `OSP_MAP_ROWS;
		// Field sync: new field, whole set goes live at once
		if (fsync)
		begin
			s_d.vline = 9'h001;
			s_d.field = !s_q.field;
			s_d.ac = s_q.sh;
			s_d.rline = 5'h00;
			s_d.row = 5'h00;
		end
		else if (hedge)
		begin
			if (s_q.vline != 9'h1FF)
				s_d.vline = nv[8:0];
			// Row and scan line counters restart at the first text line
			if (nv == vbeg)
			begin
				s_d.rline = 5'h00;
				s_d.row = 5'h00;
				s_d.busy_p = s_q.ac[`OSP_R_VPOS][5:0] != 6'h00;
			end
			else if (s_q.rline == 5'(ROW_LINES - 1))
			begin
				s_d.rline = 5'h00;
				if (s_q.row != 5'h1F)
					s_d.row = s_q.row + 5'h01;
			end
			else
				s_d.rline = s_q.rline + 5'h01;
		end
		// Scroll window: one region, only while enabled
		scroll_on = capt_m && s_q.ac[`OSP_R_STAT][`OSP_ST_SCROLL];
		win_now = scroll_on && s_q.row >= {1'b0, scroll_window_position} && s_q.row < {1'b0, scroll_window_position} + {1'b0, scroll_window_height};
		sl = s_q.rline + {1'b0, scl};
		carry = sl >= 5'(ROW_LINES);
		disp_row = {1'b0, first_scrolled_row} + (s_q.row - {1'b0, scroll_window_position}) + {4'h0, carry};
		// Row map read just after line sync on text area lines, while rows remain
		if (s_q.hcnt == 11'h000 && txt_v && s_q.row < rows_max)
		begin
			s_d.map_rd = 1'b1;
			s_d.in_win = win_now;
			s_d.map_addr = `OSP_MAP_BASE + {11'h000, win_now ? disp_row : s_q.row};
			s_d.row_ln = win_now ? 4'(carry ? sl - 5'(ROW_LINES) : sl) : 4'(s_q.rline);
			// Rows outside the range never leak into the static area
			s_d.row_blank = win_now && (disp_row > {1'b0, scroll_last_row_range} || disp_row < {1'b0, sts});
		end
		// Map word arrives one cycle after the strobe
		if (s_q.rd_pend)
		begin
			s_d.row_ptr = `OSP_MAP_BASE + {6'h00, MAP_DATA[9:0]};
			// Bit 10 is ignored; bit 11 matters only outside the window
			s_d.row_on = !s_q.row_blank && (s_q.in_win || MAP_DATA[`OSP_MAP_EN_BIT]);
		end
		// Horizontal text areas in quarter characters
		cols = tele_m ? `OSP_TELE_COLS : `OSP_MAX_CHARS;
		end_a = s_q.ac[`OSP_R_HEND][5:0] > cols ? cols : s_q.ac[`OSP_R_HEND][5:0];
		end_b = s_q.ac[`OSP_R_HENDB][5:0] > cols ? cols : s_q.ac[`OSP_R_HENDB][5:0];
		// Start counts below four are not guarded here
		a_beg = {2'b00, s_q.ac[`OSP_R_HSTA][5:0], 2'b00} + {8'h00, s_q.ac[`OSP_R_HSTA][7:6]};
		b_beg = {s_q.ac[`OSP_R_PGB], 2'b00} + {2'b00, s_q.ac[`OSP_R_HSTB][5:0], 2'b00}
			+ {8'h00, s_q.ac[`OSP_R_HSTB][7:6]};
		// End character closes the area and so the fetch
		in_ta = txt_v && s_q.row < rows_max && s_q.qcnt >= a_beg
			&& s_q.qcnt < a_beg + {2'b00, end_a, 2'b00};
		// Page B reuses page A vertical timing
		in_tb = two_pg && txt_v && s_q.row < rows_max && s_q.qcnt >= b_beg
			&& s_q.qcnt < b_beg + {2'b00, end_b, 2'b00};
		s_d.text_a = in_ta;
		s_d.text_b = in_tb;
		// Screen colour area: fixed, no offset setting
		s_d.sc_win = s_q.hcnt >= SCW_BEG && s_q.hcnt <= SCW_END
			&& s_q.hcnt >= SCA_BEG && s_q.hcnt < SCA_END
			&& s_q.vline >= `OSP_SCA_FIRST
			&& (std525 ? (s_q.vline >= `OSP_L525_FIRST && s_q.vline <= `OSP_L525_LAST)
				: (s_q.vline >= `OSP_L625_FIRST && s_q.vline <= `OSP_L625_LAST));
		// Page B has its own screen colour
		sc_cur = (two_pg && in_tb) ? s_q.ac[`OSP_R_TXB][2:0] : s_q.ac[`OSP_R_TXA][2:0];
		src_n = OSP_VIDEO;
		idx_n = 4'h0;
		if (tele_m)
		begin
			// Teletext-style mixing of picture, text, background
			if (s_q.ac[`OSP_R_TXA][`OSP_TX_TEXT] && (in_ta || in_tb) && FG_PIX)
			begin
				src_n = OSP_CLUT;
				idx_n = FG_IDX;
			end
			else if (s_q.ac[`OSP_R_TXA][`OSP_TX_TEXT] && s_q.ac[`OSP_R_TXA][`OSP_TX_BACK]
				&& (in_ta || in_tb) && BG_PIX)
			begin
				src_n = OSP_CLUT;
				idx_n = BG_IDX;
			end
			else
			begin
				// Picture shows if its bit is set, unless a full text page covers it
				if (s_q.ac[`OSP_R_TXA][`OSP_TX_PIC] && !(s_q.ac[`OSP_R_TXA][`OSP_TX_TEXT]
					&& s_q.ac[`OSP_R_TXA][`OSP_TX_BACK] && (in_ta || in_tb)))
					src_n = OSP_VIDEO;
				else
					src_n = OSP_BLACK;
				// Nonzero screen colour replaces picture and black
				if (sc_cur != 3'h0 && s_d.sc_win)
				begin
					src_n = OSP_CLUT;
					idx_n = {1'b1, sc_cur};
				end
			end
		end
		else if (s_q.ac[`OSP_R_DCTL][1:0] == 2'b00)
			src_n = OSP_VIDEO;
		else if (FG_PIX && (in_ta || in_tb))
		begin
			src_n = OSP_CLUT;
			idx_n = FG_IDX;
		end
		else if ((in_ta || in_tb) && (BG_PIX || (BOX_PIX && s_q.ac[`OSP_R_DCTL][1])))
		begin
			// Box counts only in the two mixed modes
			src_n = OSP_CLUT;
			idx_n = BG_IDX;
		end
		else if (s_q.ac[`OSP_R_DCTL][1:0] == 2'b11)
			src_n = OSP_VIDEO;
		else if (s_d.sc_win)
		begin
			src_n = OSP_CLUT;
			idx_n = s_q.ac[`OSP_R_DCTL][7:4];
		end
		else
			src_n = OSP_BLACK;
		s_d.src = src_n;
		s_d.pix_idx = idx_n;
		// Software writes land in the shadow set only
		if (WR && hit)
			s_d.sh[ri] = WDATA & WMASK[ri];
		rd_val = `OSP_RESET_BYTE;
		if (hit)
			rd_val = s_q.sh[ri];
		if (hit && ri == `OSP_R_STAT)
			rd_val = {txt_v, s_q.field, s_q.sh[`OSP_R_STAT][5:0]};
		s_d.rdata = RD ? rd_val : `OSP_RESET_BYTE;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (RST)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	assign exp_ptr = `OSP_MAP_BASE + {6'h00, MAP_DATA[9:0]};
	assign exp_on = MAP_DATA[`OSP_MAP_EN_BIT];
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	sequence s_fetch;
		s_q.map_rd ##1 s_q.rd_pend;
	endsequence
	a_map_pointer: assert property (s_fetch |=> s_q.row_ptr == $past(exp_ptr))
		else $error("row pointer not base plus map offset");
	a_map_enable: assert property (s_fetch ##0 !s_q.in_win && !s_q.row_blank
		|=> s_q.row_on == $past(exp_on))
		else $error("row enable not taken from map bit");
	a_scroll_hold: assert property (!fsync |=> $stable(s_q.ac))
		else $error("active set changed outside field sync");
	a_field_copy: assert property (fsync |=> s_q.ac == $past(s_q.sh))
		else $error("shadow set not copied at field sync");
	a_busy_gate: assert property (s_q.busy_p |-> $past(s_q.ac[`OSP_R_VPOS][5:0]) != 6'h00)
		else $error("busy pulse with zero vertical offset");
	a_sc_hwin: assert property (s_q.sc_win |-> $past(s_q.hcnt) >= 11'h0D2 && $past(s_q.hcnt) <= 11'h4E2)
		else $error("screen colour outside horizontal window");
	a_sc_vwin: assert property (s_q.sc_win && !$past(std525)
		|-> $past(s_q.vline) >= 9'h017 && $past(s_q.vline) <= 9'h136)
		else $error("screen colour outside 625-line range");
	a_mode_video: assert property (!tele_m && s_q.ac[`OSP_R_DCTL][1:0] == 2'b00 |=> s_q.src == OSP_VIDEO)
		else $error("video mode did not pass video");
	a_txt_black: assert property (tele_m && s_q.ac[`OSP_R_TXA][6:4] == 3'h0 && sc_cur == 3'h0
		|=> s_q.src == OSP_BLACK)
		else $error("text and picture off did not give black");
	a_txt_screen: assert property (tele_m && !s_q.ac[`OSP_R_TXA][`OSP_TX_TEXT] && sc_cur != 3'h0 && s_d.sc_win
		|=> s_q.src == OSP_CLUT && s_q.pix_idx == {1'b1, $past(sc_cur)})
		else $error("screen colour not shown as entry 9 to 15");
endmodule

/* File: osp_video_src.sv */
// Purpose: sync source and row map memory beside the window block
// Assumes: syncs active low, memory answers one clock after a read
// Notes: only lines 16, 17, 22 and 23 run full length, to keep fields short
`timescale 1ns/1ps

module osp_video_src
(
	input wire logic clock,
	input wire logic rst,
	input wire logic map_rd,
	input wire logic [15:0] map_addr,
	output logic hsync_n,
	output logic vsync_n,
	output logic [15:0] map_data,
	output logic [8:0] line_no,
	output logic field_start
);
	// ----------------------------------------
	// Line and field timing
	// ----------------------------------------
	int pos_q; // Clock within line
	int len; // Length of current line
	logic [15:0] junk_q = 16'hA5C3; // Filler, changes every clock
	assign len = (line_no inside {9'h010, 9'h011, 9'h016, 9'h017}) ? 1300 : 64;

	// Field sync sits mid-line, clear of line sync edges
	always @(posedge clock)
	begin
		field_start <= 1'b0;
		junk_q <= junk_q + 16'h1357;
		if (rst)
		begin
			pos_q <= 0;
			line_no <= 9'h017;
			hsync_n <= 1'b1;
			vsync_n <= 1'b1;
		end
		else
		begin
			pos_q <= (pos_q >= len - 1) ? 0 : pos_q + 1;
			hsync_n <= (pos_q < 8) ? 1'b0 : 1'b1;
			if (pos_q >= len - 1)
				line_no <= (line_no == 9'h017) ? 9'h001 : line_no + 9'h001;
			if (line_no == 9'h001 && pos_q == 32)
			begin
				vsync_n <= 1'b0;
				field_start <= 1'b1;
			end
			if (pos_q == 40)
				vsync_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// Row map memory
	// ----------------------------------------
	// Word i: enable = i[0], reserved bit zero; junk when no word is due
	always @(posedge clock)
	begin
		if (map_rd)
			map_data <= {4'h0, map_addr[0], 1'b0, 2'h2, map_addr[3:0], 4'h5};
		else
			map_data <= junk_q;
	end
endmodule

/* File: osp_screen_scroll_bench.sv */
// Purpose: self-checking bench of the screen window block
// Assumes: one-cycle strobes, read data in the next cycle
// Notes: foreground pixel held high in pixel cases, so text area shows it in the kind 2 cases
`timescale 1ns/1ps
`include "osp_consts.svh"

module osp_screen_scroll_bench
	import osp_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0] WDATA = 8'h00;
	logic [15:0] MAP_DATA, MAP_ADDR, ROW_PTR, a_d1, a_d2;
	logic [7:0] RDATA;
	logic [3:0] ROW_LINE, PIX_IDX, ex_idx;
	logic MAP_RD, ROW_ON, TEXT_A, TEXT_B, SC_WIN, DISP_BUSY, hs_n, vs_n, f_st;
	logic sc_d, rd_d1, rd_d2;
	logic cap_on = 1'b0; // Row map checks only in caption mode
	logic scr_on = 1'b0; // Scroll checks only in the one scrolled field
	logic fg_pix = 1'b0; // Foreground pixel into the block
	logic [3:0] fg_idx = 4'h0; // Foreground lookup index into the block
	osp_src_e PIX_SRC, ex_src;
	logic [8:0] line_no, line_d, b_line, b_last_line;
	int n_errors = 0;
	int checks_done = 0;
	int sc_cnt = 0;
	int b_cnt = 0;
	int b_last_cnt, pk;
	int sc_len [24]; // Screen window clocks per line
	// Pixel cases: config, display control, teletext control, kind, source
	logic [7:0] t_cfg [4] = '{8'h80, 8'h80, 8'h08, 8'h08};
	logic [7:0] t_dct [4] = '{8'h00, 8'h51, 8'h00, 8'h00};
	logic [7:0] t_txa [4] = '{8'h00, 8'h00, 8'h00, 8'h33};
	int t_kind [4] = '{1, 2, 1, 2};
	osp_src_e t_src [4] = '{OSP_VIDEO, OSP_CLUT, OSP_BLACK, OSP_CLUT};

	osp_screen_scroll #(.QTR_CYC(3), .ROW_LINES(10)) dut_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HSYNC(hs_n), .VSYNC(vs_n), .FG_PIX(fg_pix),
		.BG_PIX(1'b0), .BOX_PIX(1'b0), .FG_IDX(fg_idx), .BG_IDX(4'h0), .MAP_DATA(MAP_DATA),
		.MAP_RD(MAP_RD), .MAP_ADDR(MAP_ADDR), .ROW_PTR(ROW_PTR), .ROW_ON(ROW_ON), .ROW_LINE(ROW_LINE),
		.PIX_SRC(PIX_SRC), .PIX_IDX(PIX_IDX), .TEXT_A(TEXT_A), .TEXT_B(TEXT_B), .SC_WIN(SC_WIN),
		.DISP_BUSY(DISP_BUSY));
	osp_video_src src_u (.clock(CLOCK), .rst(RST), .map_rd(MAP_RD), .map_addr(MAP_ADDR),
		.hsync_n(hs_n), .vsync_n(vs_n), .map_data(MAP_DATA), .line_no(line_no), .field_start(f_st));

	initial
	begin
		forever #25 CLOCK = ~CLOCK;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected value at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		RD <= 1'b0;
		@(posedge CLOCK);
		chk(RDATA, e);
	endtask

	// Returns just after a field copy has landed
	task automatic next_field();
		int i;
		i = 0;
		@(posedge CLOCK);
		while (f_st !== 1'b1)
		begin
			i++;
			if (i > 40000)
			begin
				n_errors++;
				$display("unexpected hang at %0t: no field sync", $time);
				end_of_test();
			end
			@(posedge CLOCK);
		end
		repeat (12) @(posedge CLOCK);
	endtask

	// Expected window width from the 20 MHz cycle figures
	task automatic sc_chk(input logic s525);
		int w;
		w = `OSP_CYC_DN(`OSP_SCW_END_NS) - `OSP_CYC_UP(`OSP_SCW_START_NS) + 1;
		chk(16'(sc_len[16]), 16'h0000);
		chk(16'(sc_len[17]), s525 ? 16'(w) : 16'h0000);
		chk(16'(sc_len[22]), s525 ? 16'(w) : 16'h0000);
		chk(16'(sc_len[23]), 16'(w));
	endtask

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge CLOCK)
	begin
		line_d <= line_no;
		sc_d <= SC_WIN;
		rd_d1 <= MAP_RD;
		rd_d2 <= rd_d1;
		a_d1 <= MAP_ADDR;
		a_d2 <= a_d1;
		// Window width per partner line
		if (line_d != line_no)
		begin
			sc_len[line_d] <= sc_cnt;
			sc_cnt <= 0;
		end
		else if (SC_WIN === 1'b1)
			sc_cnt <= sc_cnt + 1;
		// Busy pulses in the field just ended
		if (f_st)
		begin
			b_last_cnt <= b_cnt;
			b_last_line <= b_line;
			b_cnt <= 0;
		end
		else if (DISP_BUSY === 1'b1)
		begin
			b_cnt <= b_cnt + 1;
			b_line <= line_no;
		end
		if (MAP_RD === 1'b1 && cap_on)
			chk(MAP_ADDR & 16'hFFF0, `OSP_MAP_BASE);
		if (rd_d2 === 1'b1 && cap_on)
		begin
			chk(ROW_PTR, 16'h8000 + {6'h0, 2'h2, a_d2[3:0], 4'h5});
			chk({15'h0, ROW_ON}, {15'h0, a_d2[0]});
		end
		// Scrolled row 1: mapped row and scan line follow the offset
		if (MAP_RD === 1'b1 && scr_on && line_no >= 9'h013)
		begin
			chk(MAP_ADDR, (line_no < 9'h015) ? 16'h8003 : 16'h8004);
			chk({12'h0, ROW_LINE}, 16'((line_no - 9'h00B) % 9'h00A));
		end
		// Foreground wins inside the text area
		if (pk == 2 && TEXT_A === 1'b1)
		begin
			chk(16'(PIX_SRC), 16'(OSP_CLUT));
			chk({12'h0, PIX_IDX}, {12'h0, fg_idx});
		end
		if (pk == 1)
			chk(16'(PIX_SRC), 16'(ex_src));
		if (pk == 2 && SC_WIN === 1'b1 && sc_d === 1'b1)
		begin
			chk(16'(PIX_SRC), 16'(OSP_CLUT));
			chk({12'h0, PIX_IDX}, {12'h0, ex_idx});
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		pk = 0;
		repeat (5) @(posedge CLOCK);
		RST <= 1'b0;
		rd_chk(`OSP_A_VPOS, 8'h00);
		rd_chk(`OSP_A_VPOSB, 8'h00);
		rd_chk(`OSP_A_VRNG, 8'h00);
		wr(`OSP_A_VPOSB, 8'hFF);
		rd_chk(`OSP_A_VPOSB, 8'h3F);
		wr(`OSP_A_VRNG, 8'hFF);
		rd_chk(`OSP_A_VRNG, 8'h3F);
		wr(16'h87F3, 8'hFF);
		rd_chk(16'h87F3, 8'h00);
		wr(`OSP_A_VRNG, 8'h00);
		wr(`OSP_A_VPOSB, 8'h04);
		wr(`OSP_A_VPOS, 8'h04);
		wr(`OSP_A_CFG, 8'h80);
		next_field();
		cap_on <= 1'b1;
		// New offset written early in a field must wait for the next one
		wr(`OSP_A_VPOS, 8'h08);
		wr(`OSP_A_VPOSB, 8'h08);
		// Window at row 1, one row high, range 0-3, first row 3, line offset 8
		wr(`OSP_A_SAREA, 8'h11);
		wr(`OSP_A_SRNG, 8'h30);
		wr(`OSP_A_TSL, 8'h08);
		wr(`OSP_A_STAT, 8'h23);
		next_field();
		scr_on <= 1'b1;
		// Scroll off again from the following field
		wr(`OSP_A_STAT, 8'h00);
		chk(16'(b_last_cnt), 16'h0001);
		chk({7'h0, b_last_line}, 16'h0005);
		sc_chk(1'b0);
		next_field();
		scr_on <= 1'b0;
		chk({7'h0, b_last_line}, 16'h0009);
		wr(`OSP_A_VPOS, 8'h00);
		wr(`OSP_A_VPOSB, 8'h00);
		next_field();
		next_field();
		chk(16'(b_last_cnt), 16'h0000);
		wr(`OSP_A_TXB, 8'h80);
		next_field();
		next_field();
		sc_chk(1'b1);
		cap_on <= 1'b0;
		// Text area A from char 4 for 8 chars, clear of the screen window
		wr(`OSP_A_HSTA, 8'h04);
		wr(`OSP_A_HEND, 8'h08);
		fg_pix <= 1'b1;
		fg_idx <= 4'hC;
		for (int k = 0; k < 4; k++)
		begin
			wr(`OSP_A_CFG, t_cfg[k]);
			wr(`OSP_A_DCTL, t_dct[k]);
			wr(`OSP_A_TXA, t_txa[k]);
			next_field();
			ex_src <= t_src[k];
			ex_idx <= t_cfg[k][7] ? t_dct[k][7:4] : 4'h8 + {1'b0, t_txa[k][2:0]};
			pk <= t_kind[k];
			next_field();
			pk <= 0;
		end
		end_of_test();
	end
endmodule
